// File: include/irq_prio_pkg.sv
// constants for the vectored interrupt prioritizer
package irq_prio_pkg;
   // maskable source count and index of selected sources, in table order
   localparam int NUM_SRC    = 17;
   localparam int IDX_T1     = 0;
   localparam int IDX_T0     = 1;
   localparam int IDX_URX    = 2;
   localparam int IDX_UTX    = 3;
   localparam int IDX_ADC    = 4;
   localparam int IDX_PA7    = 5;
   localparam int IDX_PA6    = 6;
   localparam int IDX_PA3    = 9;
   localparam int IDX_PA2    = 10;
   localparam int IDX_PC3    = 13;
   localparam int NUM_PA     = 8;
   localparam int NUM_PC     = 4;
   // trap count: watchdog, primary osc, watchdog osc, illegal
   localparam int NUM_TRAP   = 4;
   localparam int TRAP_WDT   = 0;
   localparam int TRAP_POSC  = 1;
   localparam int TRAP_WOSC  = 2;
   localparam int TRAP_ILL   = 3;
   // vector addresses
   localparam logic [15:0] VEC_WDT  = 16'h0004;
   localparam logic [15:0] VEC_POSC = 16'h003A;
   localparam logic [15:0] VEC_WOSC = 16'h003C;
   localparam logic [15:0] VEC_ILL  = 16'h0006;
   localparam logic [15:0] VEC_T1   = 16'h000A;
   localparam logic [15:0] VEC_T0   = 16'h000C;
   localparam logic [15:0] VEC_URX  = 16'h000E;
   localparam logic [15:0] VEC_UTX  = 16'h0010;
   localparam logic [15:0] VEC_ADC  = 16'h0016;
   localparam logic [15:0] VEC_PA7  = 16'h0018;
   localparam logic [15:0] VEC_PC3  = 16'h0030;
   localparam logic [15:0] VEC_STEP = 16'h0002;
   // enable pair encodings
   localparam logic [1:0] LVL_OFF   = 2'h0;
   localparam logic [1:0] LVL_TOP   = 2'h3;
   localparam logic [NUM_SRC-1:0] PEND_RESET = 17'h0_0000;
endpackage

// File: logic/level_ranker.sv
// finds the highest-ranked pending source at one priority level
`timescale 1ns/1ns
module level_ranker #(
   parameter int N = 17
) (
   input  wire logic [N-1:0]         hit_in,
   output logic                      any_out,
   output logic [$clog2(N)-1:0]      idx_out
);
   // lowest index is highest rank; scan from index N-1 down so the lowest hit is kept
   always_comb begin
      idx_out = '0;
      any_out = 1'b0;
      for (int i = N - 1; i >= 0; i--) begin
         if (hit_in[i]) begin
            idx_out = ($clog2(N))'(i);
            any_out = 1'b1;
         end
      end
   end
endmodule

// File: logic/vectored_interrupt_prioritizer.sv
// interrupt prioritizer: request latching, levels, vector selection
`timescale 1ns/1ns
module vectored_interrupt_prioritizer (
   input  wire logic        clk_in,
   input  wire logic        nrst_in,
   // single-clock request pulses from peripherals and pins
   input  wire logic        timer1_req_in,
   input  wire logic        timer0_req_in,
   input  wire logic        uart_rx_req_in,
   input  wire logic        uart_tx_req_in,
   input  wire logic        adc_req_in,
   input  wire logic [7:0]  port_a_req_in,
   input  wire logic        comparator_req_in,
   input  wire logic [3:2]  port_d_req_in,
   input  wire logic [3:0]  port_c_req_in,
   // trap and watchdog pulses, plus the watchdog interrupt enable level
   input  wire logic        wdt_req_in,
   input  wire logic        wdt_irq_enable_in,
   input  wire logic        posc_fail_in,
   input  wire logic        wosc_fail_in,
   input  wire logic        illegal_inst_in,
   input  wire logic        trap_instruction_in,
   // cpu instruction strobes
   input  wire logic        enable_interrupts_instruction_in,
   input  wire logic        disable_interrupts_instruction_in,
   input  wire logic        return_from_interrupt_instruction_in,
   // software access to the global enable flag
   input  wire logic        flag_write_in,
   input  wire logic        flag_wdata_in,
   // software access to the request bits (one write per cycle)
   input  wire logic        pend_write_in,
   input  wire logic [16:0] pend_wdata_in,
   // per-source enable pairs
   input  wire logic [16:0] enable_high_bits_in,
   input  wire logic [16:0] enable_low_bits_in,
   // cpu acknowledge
   input  wire logic        cpu_ack_in,
   output logic             cpu_irq_out,
   output logic [15:0]      vector_out,
   output logic [16:0]      pending_out,
   output logic [3:0]       trap_pending_out,
   output logic             global_irq_enable_flag_out
);
   localparam int N  = irq_prio_pkg::NUM_SRC;
   localparam int IW = $clog2(N);

   // reset release through two flops
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // gather hardware pulses into source order
   logic [N-1:0] hw_pulse;
   assign hw_pulse[irq_prio_pkg::IDX_T1]  = timer1_req_in;
   assign hw_pulse[irq_prio_pkg::IDX_T0]  = timer0_req_in;
   assign hw_pulse[irq_prio_pkg::IDX_URX] = uart_rx_req_in;
   assign hw_pulse[irq_prio_pkg::IDX_UTX] = uart_tx_req_in;
   assign hw_pulse[irq_prio_pkg::IDX_ADC] = adc_req_in;

   // port A pins, descending pin order, with shared sources merged
   genvar g;
   generate
      for (g = 0; g < irq_prio_pkg::NUM_PA; g++) begin : g_pa
         localparam int IDX = irq_prio_pkg::IDX_PA7 + g;
         localparam int PIN = 7 - g;
         if (IDX == irq_prio_pkg::IDX_PA6) begin : g_cmp
            assign hw_pulse[IDX] = port_a_req_in[PIN]
                                   | comparator_req_in;
         end else if (IDX == irq_prio_pkg::IDX_PA3 ||
                      IDX == irq_prio_pkg::IDX_PA2) begin : g_pd
            assign hw_pulse[IDX] = port_a_req_in[PIN]
                                   | port_d_req_in[PIN];
         end else begin : g_plain
            assign hw_pulse[IDX] = port_a_req_in[PIN];
         end
      end
      // port C pins 3..0 rank last; edge detection is upstream
      for (g = 0; g < irq_prio_pkg::NUM_PC; g++) begin : g_pc
         assign hw_pulse[irq_prio_pkg::IDX_PC3 + g] =
            port_c_req_in[3 - g];
      end
   endgenerate

   // priority level of each source from its enable pair
   logic [N-1:0] lvl_hit [1:3];
   logic [N-1:0] pend;
   logic         flag;
   generate
      for (g = 0; g < N; g++) begin : g_lvl
         wire logic [1:0] code = {enable_high_bits_in[g],
                                  enable_low_bits_in[g]};
         assign lvl_hit[1][g] = pend[g] && code == 2'h1;
         assign lvl_hit[2][g] = pend[g] && code == 2'h2;
         assign lvl_hit[3][g] = pend[g] && code == irq_prio_pkg::LVL_TOP;
      end
   endgenerate

   // one ranker per level
   logic          lvl_any [1:3];
   logic [IW-1:0] lvl_idx [1:3];
   generate
      for (g = 1; g <= 3; g++) begin : g_rank
         level_ranker #(.N(N)) u_rank (
            .hit_in  (lvl_hit[g]),
            .any_out (lvl_any[g]),
            .idx_out (lvl_idx[g])
         );
      end
   endgenerate

   // winner among maskable sources: highest level first
   wire logic          mask_any = lvl_any[3] | lvl_any[2] | lvl_any[1];
   wire logic [IW-1:0] win_idx  = lvl_any[3] ? lvl_idx[3] :
                                  lvl_any[2] ? lvl_idx[2] :
                                  lvl_idx[1];

   // trap pending bits; the watchdog counts only when enabled
   logic [3:0] trap;
   logic [3:0] trap_set;
   assign trap_set = {illegal_inst_in, wosc_fail_in, posc_fail_in,
                      wdt_req_in & wdt_irq_enable_in};
   wire logic trap_any = |trap;

   // trap vector in fixed order: wdt, posc, wosc, illegal
   logic [15:0] trap_vec;
   logic [3:0]  trap_win;
   always_comb begin
      trap_vec = irq_prio_pkg::VEC_ILL;
      trap_win = 4'h8;
      if (trap[irq_prio_pkg::TRAP_WDT]) begin
         trap_vec = irq_prio_pkg::VEC_WDT;
         trap_win = 4'h1;
      end else if (trap[irq_prio_pkg::TRAP_POSC]) begin
         trap_vec = irq_prio_pkg::VEC_POSC;
         trap_win = 4'h2;
      end else if (trap[irq_prio_pkg::TRAP_WOSC]) begin
         trap_vec = irq_prio_pkg::VEC_WOSC;
         trap_win = 4'h4;
      end
   end

   // maskable vector address from the winner index
   function automatic logic [15:0] src_vec(input logic [IW-1:0] idx);
      if (idx >= IW'(irq_prio_pkg::IDX_PC3))
         src_vec = irq_prio_pkg::VEC_PC3 + irq_prio_pkg::VEC_STEP *
                   16'(idx - IW'(irq_prio_pkg::IDX_PC3));
      else if (idx >= IW'(irq_prio_pkg::IDX_PA7))
         src_vec = irq_prio_pkg::VEC_PA7 + irq_prio_pkg::VEC_STEP *
                   16'(idx - IW'(irq_prio_pkg::IDX_PA7));
      else if (idx == IW'(irq_prio_pkg::IDX_ADC))
         src_vec = irq_prio_pkg::VEC_ADC;
      else
         src_vec = irq_prio_pkg::VEC_T1 + irq_prio_pkg::VEC_STEP *
                   16'(idx);
   endfunction

   // traps beat every maskable source whatever its level
   wire logic          want     = trap_any | mask_any;
   wire logic [15:0]   next_vec = trap_any ? trap_vec
                                           : src_vec(win_idx);
   // the flag gates only maskable requests; polled mode stays quiet
   wire logic          irq_now  = trap_any | (flag & mask_any);
   wire logic          take     = cpu_ack_in & irq_now;

   // one-hot clear for the acknowledged source
   logic [N-1:0] ack_clr;
   assign ack_clr = (take && !trap_any) ? (N'(1) << win_idx)
                                        : '0;

   // pending: software write, then acknowledge clear, then pulses win
   logic [N-1:0] next_pend;
   always_comb begin
      next_pend = pend;
      if (pend_write_in)
         next_pend = pend_wdata_in;
      next_pend = next_pend & ~ack_clr;
      next_pend = next_pend | hw_pulse;
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n)
         pend <= irq_prio_pkg::PEND_RESET;
      else
         pend <= next_pend;
   end

   // trap bits: set by event, cleared when acknowledged
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n)
         trap <= 4'h0;
      else
         trap <= (trap & ~((take && trap_any) ? trap_win : 4'h0))
                 | trap_set;
   end

   // global enable flag: clears dominate sets within one cycle
   wire logic flag_set = enable_interrupts_instruction_in
                       | return_from_interrupt_instruction_in
                       | (flag_write_in & flag_wdata_in);
   wire logic flag_clr = disable_interrupts_instruction_in | take
                       | (flag_write_in & ~flag_wdata_in)
                       | trap_instruction_in | illegal_inst_in
                       | posc_fail_in | wosc_fail_in;
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n)
         flag <= 1'b0;
      else if (flag_clr)
         flag <= 1'b0;
      else if (flag_set)
         flag <= 1'b1;
   end

   // registered vector, reloaded only while a trap or an enabled maskable request is pending
   logic [15:0] vec_q;
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n)
         vec_q <= 16'h0000;
      else if (want)
         vec_q <= next_vec;
   end

   assign cpu_irq_out                = irq_now;
   assign vector_out                 = vec_q;
   assign pending_out                = pend;
   assign trap_pending_out           = trap;
   assign global_irq_enable_flag_out = flag;

   // a pulse on source 0 always lands in its pending bit
   a_pulse_latched: assert property (@(posedge clk_in) disable iff (!rst_n)
      hw_pulse[0] |=> pend[0]) else $error("pulse lost");
   // no maskable interrupt without the flag
   a_polled_quiet: assert property (@(posedge clk_in) disable iff (!rst_n)
      (!trap_any && !flag) |-> !cpu_irq_out)
      else $error("irq while disabled");
   // acknowledge drops the flag
   a_ack_flag: assert property (@(posedge clk_in) disable iff (!rst_n)
      take |=> !flag) else $error("flag kept after ack");
   // enable instruction raises the flag absent a clear
   a_ei_sets: assert property (@(posedge clk_in) disable iff (!rst_n)
      (enable_interrupts_instruction_in && !flag_clr) |=> flag)
      else $error("flag not set");
   // the watchdog trap beats maskable sources in the vector
   a_trap_top: assert property (@(posedge clk_in) disable iff (!rst_n)
      (trap[irq_prio_pkg::TRAP_WDT]) |=> vector_out == irq_prio_pkg::VEC_WDT)
      else $error("trap vector wrong");
   // acknowledge clears winner unless a new pulse arrives
   a_ack_clears: assert property (@(posedge clk_in) disable iff (!rst_n)
      (take && !trap_any && win_idx == 0 && !hw_pulse[0] && !pend_write_in)
      |=> !pend[0]) else $error("winner not cleared");
   // level 3 wins over level 1 and 2
   a_level_order: assert property (@(posedge clk_in) disable iff (!rst_n)
      (lvl_any[3] && !trap_any) |=> vector_out == $past(src_vec(lvl_idx[3])))
      else $error("level order wrong");
   // software write lands when no pulse or ack
   a_sw_write: assert property (@(posedge clk_in) disable iff (!rst_n)
      (pend_write_in && !take && hw_pulse == '0)
      |=> pend == $past(pend_wdata_in))
      else $error("write lost");
endmodule

// File: testbench/cpu_core_model.sv
// cpu core model that acknowledges requests after a chosen wait
`timescale 1ns/1ns
module cpu_core_model (
   input  wire logic        clk_in,
   input  wire logic        nrst_in,
   input  wire logic        auto_in,
   input  wire logic [2:0]  wait_in,
   input  wire logic        cpu_irq_in,
   input  wire logic [15:0] vector_in,
   output logic             cpu_ack_out,
   output logic [15:0]      taken_vec_out
);
   logic [2:0] cnt;
   // waits wait_in cycles so the vector has settled, then one ack pulse
   always @(negedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cnt <= 3'h0;
         cpu_ack_out <= 1'b0;
         taken_vec_out <= 16'h0000;
      end else if (cpu_ack_out) begin
         cnt <= 3'h0;
         cpu_ack_out <= 1'b0;
      end else if (auto_in && cpu_irq_in) begin
         cnt <= cnt + 3'h1;
         cpu_ack_out <= (cnt >= wait_in);
         taken_vec_out <= vector_in;
      end else begin
         cnt <= 3'h0;
      end
   end
endmodule

// File: testbench/tb_vectored_interrupt_prioritizer.sv
// self-checking bench for the vectored interrupt prioritizer
`timescale 1ns/1ns
module tb_vectored_interrupt_prioritizer;
   logic        clk_in, nrst_in, cpu_ack, irq, flag, auto;
   logic        t1, t0, urx, utx, adc, cmp, wdt, wdt_en, posc, wosc, ill;
   logic        trapi, ei, di, return_from_interrupt_instruction, fw, fwd, pw;
   logic [7:0]  pa;
   logic [3:2]  pd;
   logic [3:0]  pc, trp;
   logic [2:0]  wt;
   logic [15:0] vec, tvec;
   logic [16:0] pwd, enh, enl, pend, p;
   logic [15:0] expq[$];
   int          n_fail, num_checks, cyc, seed;

   vectored_interrupt_prioritizer u_vectored_interrupt_prioritizer (
      .clk_in(clk_in), .nrst_in(nrst_in), .timer1_req_in(t1),
      .timer0_req_in(t0), .uart_rx_req_in(urx), .uart_tx_req_in(utx),
      .adc_req_in(adc), .port_a_req_in(pa), .comparator_req_in(cmp),
      .port_d_req_in(pd), .port_c_req_in(pc), .wdt_req_in(wdt),
      .wdt_irq_enable_in(wdt_en), .posc_fail_in(posc), .wosc_fail_in(wosc),
      .illegal_inst_in(ill), .trap_instruction_in(trapi),
      .enable_interrupts_instruction_in(ei),
      .disable_interrupts_instruction_in(di),
      .return_from_interrupt_instruction_in(return_from_interrupt_instruction),
      .flag_write_in(fw), .flag_wdata_in(fwd), .pend_write_in(pw),
      .pend_wdata_in(pwd), .enable_high_bits_in(enh),
      .enable_low_bits_in(enl), .cpu_ack_in(cpu_ack), .cpu_irq_out(irq),
      .vector_out(vec), .pending_out(pend), .trap_pending_out(trp),
      .global_irq_enable_flag_out(flag));

   cpu_core_model u_cpu_core_model (
      .clk_in(clk_in), .nrst_in(nrst_in), .auto_in(auto), .wait_in(wt),
      .cpu_irq_in(irq), .vector_in(vec), .cpu_ack_out(cpu_ack),
      .taken_vec_out(tvec));

   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   task automatic check(input logic [16:0] seen, exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // a hang counts as a mismatch
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         summarize();
      end
   end

   // each ack takes the oldest expected vector off the queue
   always @(posedge clk_in) begin
      if (cpu_ack === 1'b1)
         check(tvec, expq.size() > 0 ? expq.pop_front() : 17'h1_0000,
               "vector");
   end

   task automatic idle;
      {t1, t0, urx, utx, adc, cmp, wdt, posc, wosc, ill} = '0;
      {trapi, ei, di, return_from_interrupt_instruction, fw, fwd, pw} = '0;
      pa = 8'h00;
      pd = 2'h0;
      pc = 4'h0;
   endtask

   // one-clock request pulses by source index and trap mask
   task automatic pulse(input logic [16:0] m, input logic [3:0] x);
      {adc, utx, urx, t0, t1} = m[4:0];
      pa = {<<{m[12:5]}};
      pc = {<<{m[16:13]}};
      {ill, wosc, posc, wdt} = x;
      @(negedge clk_in);
      idle();
   endtask

   task automatic flag_set(input int k);
      case (k % 3)
         0: ei = 1'b1;
         1: return_from_interrupt_instruction = 1'b1;
         default: {fw, fwd} = 2'b11;
      endcase
      @(negedge clk_in);
      idle();
   endtask

   task automatic drain;
      repeat (40) if (expq.size() > 0) @(negedge clk_in);
      check(17'(expq.size()), 17'h0, "acks seen");
   endtask

   function automatic int winner(input logic [16:0] m);
      for (int l = 3; l > 0; l--)
         for (int i = 0; i < 17; i++)
            if (m[i] && {enh[i], enl[i]} == 2'(l)) return i;
      return -1;
   endfunction

   function automatic logic [15:0] vec_of(input int i);
      if (i < 4)
         return irq_prio_pkg::VEC_T1 + irq_prio_pkg::VEC_STEP * 16'(i);
      if (i == 4) return irq_prio_pkg::VEC_ADC;
      if (i < 13) return irq_prio_pkg::VEC_PA7 + 16'h0002 * 16'(i - 5);
      return irq_prio_pkg::VEC_PC3 + 16'h0002 * 16'(i - 13);
   endfunction

   // serves every enabled request one by one, re-enabling between acks
   task automatic serve(input logic [16:0] m);
      for (int w = winner(m); w >= 0; w = winner(m)) begin
         wt = 3'({1'b0, 2'($random(seed))} + 3'h1);
         expq.push_back(vec_of(w));
         flag_set(w);
         drain();
         m[w] = 1'b0;
      end
      check(pend, m, "leftover");
   endtask

   initial begin
      seed = 32'h6ea0_c01e;
      {nrst_in, pw, fw, fwd} = '0;
      {auto, wdt_en, wt} = {2'b11, 3'h1};
      {pwd, enh, enl} = '0;
      idle();
      repeat (16) @(negedge clk_in);
      check(17'(flag), 17'h0, "reset flag");
      check(pend, 17'h0, "reset pend");
      nrst_in = 1'b1;
      repeat (3) @(negedge clk_in);
      // all sources at one level come out in table order
      enh = 17'h1_ffff;
      pulse(17'h1_ffff, 4'h0);
      serve(17'h1_ffff);
      $display("test order done");
      // random levels over software-set requests
      repeat (6) begin
         {enh, enl, p} = {17'($random(seed)), 17'($random(seed)),
                          17'($random(seed))};
         {pw, pwd} = {1'b1, p};
         @(negedge clk_in);
         idle();
         serve(p);
         pw = 1'b1;
         pwd = 17'h0;
         @(negedge clk_in);
         idle();
         check(pend, 17'h0, "sw clear");
      end
      $display("test levels done");
      // every clear event of the enable flag except acknowledge, traps held while cpu is idle
      auto = 1'b0;
      for (int k = 0; k < 6; k++) begin
         flag_set(k);
         check(flag, 1'b1, "flag set");
         case (k)
            0: di = 1'b1;
            1: trapi = 1'b1;
            2: fw = 1'b1;
            3: ill = 1'b1;
            4: posc = 1'b1;
            default: wosc = 1'b1;
         endcase
         @(negedge clk_in);
         idle();
         check(flag, 1'b0, "flag clear");
      end
      check(trp, 4'he, "traps held");
      wdt_en = 1'b0;
      pulse(17'h0, 4'h1);
      check(trp, 4'he, "wdt masked");
      wdt_en = 1'b1;
      pulse(17'h0, 4'h1);
      check(trp, 4'hf, "wdt taken");
      expq = '{irq_prio_pkg::VEC_WDT, irq_prio_pkg::VEC_POSC,
               irq_prio_pkg::VEC_WOSC, irq_prio_pkg::VEC_ILL};
      auto = 1'b1;
      drain();
      check(trp, 4'h0, "traps served");
      $display("test traps done");
      // polled mode, shared pins, hardware pulse beside a software clear
      {enh, enl} = '1;
      {pd, cmp} = 3'b111;
      @(negedge clk_in);
      idle();
      repeat (4) begin
         @(negedge clk_in);
         check(irq, 1'b0, "polled irq");
      end
      check(pend, 17'h0_0640, "shared pins");
      {pw, pwd, t1} = {1'b1, 17'h0, 1'b1};
      @(negedge clk_in);
      idle();
      check(pend, 17'h0_0001, "pulse wins");
      {pw, pwd} = {1'b1, 17'h0};
      @(negedge clk_in);
      idle();
      $display("test polled done");
      summarize();
   end
endmodule
